// ===== src/isa_dma_pkg.sv
// Package: constants and carrier types for the ISA DMA address mapping block
package isa_dma_pkg;
    // MCU side address decode
    localparam logic [15:0] IO_BASE_REG_ADDR = 16'h7F71;
    localparam logic [7:0]  IO_WINDOW_PAGE   = 8'h40;
    localparam logic [11:0] DMA_IO_BASE      = 12'h000;
    localparam logic [7:0]  IO_BASE_RESET    = 8'h00;
    // Runtime register offsets inside the 16-location block
    localparam logic [3:0] OFF_CHAN_LAST    = 4'h7;
    localparam logic [3:0] OFF_STATUS_CMD   = 4'h8;
    localparam logic [3:0] OFF_REQUEST      = 4'h9;
    localparam logic [3:0] OFF_SINGLE_MASK  = 4'hA;
    localparam logic [3:0] OFF_MODE         = 4'hB;
    localparam logic [3:0] OFF_CLEAR_PTR    = 4'hC;
    localparam logic [3:0] OFF_MASTER_CLEAR = 4'hD;
    localparam logic [3:0] OFF_CLEAR_MASK   = 4'hE;
    localparam logic [3:0] OFF_ALL_MASK     = 4'hF;
    // Field positions
    localparam int CMD_DISABLE_BIT = 2;
    localparam int MODE_AUTO_BIT   = 4;
    localparam int MODE_DEC_BIT    = 5;
    localparam int MASK_SET_BIT    = 2;
    localparam int INTERNAL_EXTERNAL_SELECT_BIT     = 15;
    localparam int IO_CAPABLE_MIN  = 2;
    // Reset values
    localparam logic [3:0]  MASK_RESET  = 4'hF;
    localparam logic [7:0]  READ_ZERO   = 8'h00;
    localparam logic [15:0] COUNT_LAST  = 16'h0000;
    localparam logic [4:0]  SA_HIGH_LOW = 5'h00;
    // Transfer types in mode bits 3:2
    localparam logic [1:0] XFER_VERIFY = 2'h0;
    localparam logic [1:0] XFER_WRITE  = 2'h1;
    localparam logic [1:0] XFER_READ   = 2'h2;
    // Packet window geometry
    localparam logic [9:0] WINDOW_LAST   = 10'h3FF;
    localparam int         HEADER_BYTES  = 8;
    localparam int         XFER_LIMIT    = 1024;
    localparam int         PAYLOAD_LIMIT = XFER_LIMIT - HEADER_BYTES;
    localparam int         PAGE_BYTES    = 128;
    localparam int         PAGES_MAX     = 10;
    // Data FIFO shape
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;

    // One memory cycle handed to the ISA bus or the page remapping unit
    typedef struct packed {
        logic        internal_external_select;
        logic        io_cycle;
        logic        write;
        logic [4:0]  packet_number_field;
        logic [10:0] pointer;
        logic [2:0]  page;
        logic [19:0] isa_addr;
        logic [7:0]  data;
    } mem_request_type;

    // Microcontroller I/O cycle forwarded to the ISA bus
    typedef struct packed {
        logic        write;
        logic [15:0] addr;
        logic [7:0]  data;
    } io_cycle_type;
endpackage

// ===== src/isa_dma_address_mapping.sv
// ISA DMA runtime registers, channel address mapping and data FIFO
`timescale 1ns/1ps
`default_nettype none

module isa_dma_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk_in,
    input  wire logic             reset_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             push;
    logic             pop;

    // Ready and valid are flops so the port sees no logic path
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    assign out_data_out  = mem_q[rd_q];
    assign count_d       = count_q + (AW+1)'(push) - (AW+1)'(pop);

    // Storage and pointers
    always_ff @(posedge sys_clk_in)
    begin
        if (push)
            mem_q[wr_q] <= in_data_in;
        if (reset_in)
        begin
            wr_q          <= '0;
            rd_q          <= '0;
            count_q       <= '0;
            in_ready_out  <= 1'b0;
            out_valid_out <= 1'b0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + AW'(1);
            if (pop)
                rd_q <= rd_q + AW'(1);
            count_q       <= count_d;
            in_ready_out  <= count_d != (AW+1)'(DEPTH);
            out_valid_out <= count_d != '0;
        end
    end
endmodule

module isa_dma_address_mapping (
    input  wire logic                         sys_clk_in,
    input  wire logic                         reset_in,
    input  wire logic [15:0]                  mcu_addr_in,
    input  wire logic                         mcu_wr_in,
    input  wire logic                         mcu_rd_in,
    input  wire logic [7:0]                   mcu_wdata_in,
    output logic      [7:0]                   mcu_rdata_out,
    output logic                              mcu_rvalid_out,
    output isa_dma_pkg::io_cycle_type         isa_io_out,
    output logic                              isa_io_valid_out,
    input  wire logic [3:0]                   dreq_in,
    output logic      [3:0]                   dack_out,
    output logic                              hold_request_out,
    input  wire logic                         hold_ack_in,
    input  wire logic                         dma_data_valid_in,
    output logic                              dma_data_ready_out,
    input  wire logic [7:0]                   dma_data_in,
    output isa_dma_pkg::mem_request_type      mem_req_out,
    output logic                              mem_req_valid_out,
    input  wire logic                         mem_ready_in,
    output logic      [3:0]                   tc_out
);
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } engine_state_type;

    engine_state_type state_q;
    logic [15:0] base_addr_q  [4];
    logic [15:0] cur_addr_q   [4];
    logic [15:0] base_count_q [4];
    logic [15:0] cur_count_q  [4];
    logic [7:0]  mode_q       [4];
    logic [7:0]  io_window_base_q;
    logic [7:0]  command_q;
    logic [3:0]  mask_q;
    logic [3:0]  soft_req_q;
    logic [3:0]  tc_flag_q;
    logic        byte_pointer_q;
    logic [1:0]  active_q;
    logic        fifo_valid;
    logic        fifo_pop;
    logic [7:0]  fifo_data;
    logic        io_window_hit;
    logic [15:0] io_addr;
    logic        dma_hit;
    logic [3:0]  off;
    logic        reg_wr;
    logic        reg_rd;
    logic        chan_access;
    logic [1:0]  off_ch;
    logic [3:0]  pending;
    logic [1:0]  pick;
    logic        start;
    logic        done;
    logic        last_count;
    logic        window_end;
    logic [15:0] next_addr;
    logic [7:0]  read_value;

    // Data from the I/O side is buffered so a stalled memory slows the source
    isa_dma_fifo #(
        .WIDTH (isa_dma_pkg::FIFO_WIDTH),
        .DEPTH (isa_dma_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in    (sys_clk_in),
        .reset_in      (reset_in),
        .in_valid_in   (dma_data_valid_in),
        .in_ready_out  (dma_data_ready_out),
        .in_data_in    (dma_data_in),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_data)
    );

    // MCU decode: window base gives ISA I/O bits 15:8
    assign io_window_hit = mcu_addr_in[15:8] == isa_dma_pkg::IO_WINDOW_PAGE;
    assign io_addr       = {io_window_base_q, mcu_addr_in[7:0]};
    assign dma_hit       = io_window_hit && io_addr[15:4] == isa_dma_pkg::DMA_IO_BASE;
    assign off           = io_addr[3:0];
    // Writes while the bus is held would corrupt a live channel, so refuse them
    assign reg_wr        = dma_hit && mcu_wr_in && !hold_ack_in;
    assign reg_rd        = dma_hit && mcu_rd_in;
    assign chan_access   = (reg_wr || reg_rd) && off <= isa_dma_pkg::OFF_CHAN_LAST;
    assign off_ch        = off[2:1];

    // Channel pending and fixed priority, channel 0 highest
    assign pending = (dreq_in | soft_req_q) & ~mask_q;
    always_comb
    begin
        pick = 2'h0;
        for (int i = 3; i >= 0; i--)
            if (pending[i])
                pick = 2'(i);
    end

    assign start = state_q == ST_IDLE && hold_ack_in && pending != 4'h0
                   && !command_q[isa_dma_pkg::CMD_DISABLE_BIT]
                   && (mode_q[pick][3:2] != isa_dma_pkg::XFER_WRITE || fifo_valid);
    assign fifo_pop   = start && mode_q[pick][3:2] == isa_dma_pkg::XFER_WRITE;
    assign done       = state_q == ST_WAIT && mem_ready_in;
    assign last_count = cur_count_q[active_q] == isa_dma_pkg::COUNT_LAST;
    // An internal transfer raises terminal count at the edge of its 1 KB packet window
    assign window_end = mem_req_out.internal_external_select
                        && mem_req_out.pointer[9:0] == (mode_q[active_q][isa_dma_pkg::MODE_DEC_BIT]
                           ? 10'h000 : isa_dma_pkg::WINDOW_LAST);
    assign next_addr  = mode_q[active_q][isa_dma_pkg::MODE_DEC_BIT]
                        ? cur_addr_q[active_q] - 16'h0001 : cur_addr_q[active_q] + 16'h0001;

    // Engine sequencing and the memory request it drives
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            state_q           <= ST_IDLE;
            active_q          <= 2'h0;
            mem_req_out       <= '0;
            mem_req_valid_out <= 1'b0;
            dack_out          <= 4'h0;
            hold_request_out  <= 1'b0;
            tc_out            <= 4'h0;
        end
        else
        begin
            hold_request_out <= pending != 4'h0 && !command_q[isa_dma_pkg::CMD_DISABLE_BIT];
            tc_out           <= 4'h0;
            unique case (state_q)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state_q  <= ST_WAIT;
                        active_q <= pick;
                        dack_out <= 4'h1 << pick;
                        mem_req_valid_out <= 1'b1;
                        mem_req_out.internal_external_select <= cur_addr_q[pick][isa_dma_pkg::INTERNAL_EXTERNAL_SELECT_BIT];
                        // Lower 32 KB external; plus I/O cycle on upper channels
                        mem_req_out.io_cycle <= !cur_addr_q[pick][isa_dma_pkg::INTERNAL_EXTERNAL_SELECT_BIT]
                                                && pick >= 2'(isa_dma_pkg::IO_CAPABLE_MIN);
                        mem_req_out.write <= mode_q[pick][3:2] == isa_dma_pkg::XFER_WRITE;
                        // Window index is the packet number: 0x8000 is packet 0
                        mem_req_out.packet_number_field <= cur_addr_q[pick][14:10];
                        mem_req_out.pointer <= {1'b0, cur_addr_q[pick][9:0]};
                        // Remapper sees page and offset, the channel sees flat RAM
                        mem_req_out.page <= cur_addr_q[pick][9:7];
                        mem_req_out.isa_addr <= {isa_dma_pkg::SA_HIGH_LOW, cur_addr_q[pick][14:0]};
                        mem_req_out.data <= fifo_pop ? fifo_data : isa_dma_pkg::READ_ZERO;
                    end
                end
                ST_WAIT:
                begin
                    if (mem_ready_in)
                    begin
                        state_q           <= ST_IDLE;
                        dack_out          <= 4'h0;
                        mem_req_valid_out <= 1'b0;
                        if (last_count || window_end)
                            tc_out[active_q] <= 1'b1;
                    end
                end
            endcase
        end
    end

    // MCU window base register at its own MCU address
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
            io_window_base_q <= isa_dma_pkg::IO_BASE_RESET;
        else if (mcu_wr_in && mcu_addr_in == isa_dma_pkg::IO_BASE_REG_ADDR)
            io_window_base_q <= mcu_wdata_in;
    end

    // Byte pointer: toggles per channel access, cleared by clear or master clear
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
            byte_pointer_q <= 1'b0;
        else if (reg_wr && (off == isa_dma_pkg::OFF_CLEAR_PTR || off == isa_dma_pkg::OFF_MASTER_CLEAR))
            byte_pointer_q <= 1'b0;
        else if (chan_access)
            byte_pointer_q <= !byte_pointer_q;
    end

    // Channel address and count: software byte writes or engine updates
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            for (int i = 0; i < 4; i++)
            begin
                base_addr_q[i]  <= '0;
                cur_addr_q[i]   <= '0;
                base_count_q[i] <= '0;
                cur_count_q[i]  <= '0;
            end
        end
        else if (reg_wr && off <= isa_dma_pkg::OFF_CHAN_LAST)
        begin
            // Base and current take the same byte at once
            if (!off[0] && !byte_pointer_q)
            begin
                base_addr_q[off_ch][7:0] <= mcu_wdata_in;
                cur_addr_q[off_ch][7:0]  <= mcu_wdata_in;
            end
            else if (!off[0])
            begin
                base_addr_q[off_ch][15:8] <= mcu_wdata_in;
                cur_addr_q[off_ch][15:8]  <= mcu_wdata_in;
            end
            else if (!byte_pointer_q)
            begin
                base_count_q[off_ch][7:0] <= mcu_wdata_in;
                cur_count_q[off_ch][7:0]  <= mcu_wdata_in;
            end
            else
            begin
                base_count_q[off_ch][15:8] <= mcu_wdata_in;
                cur_count_q[off_ch][15:8]  <= mcu_wdata_in;
            end
        end
        else if (done)
        begin
            if ((last_count || window_end) && mode_q[active_q][isa_dma_pkg::MODE_AUTO_BIT])
            begin
                cur_addr_q[active_q]  <= base_addr_q[active_q];
                cur_count_q[active_q] <= base_count_q[active_q];
            end
            else
            begin
                // Bit 15 is kept so a transfer never crosses internal/external
                cur_addr_q[active_q]  <= {cur_addr_q[active_q][15], next_addr[14:0]};
                cur_count_q[active_q] <= cur_count_q[active_q] - 16'h0001;
            end
        end
    end

    // Command, mode, masks, software requests and terminal count flags
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in || (reg_wr && off == isa_dma_pkg::OFF_MASTER_CLEAR))
        begin
            command_q  <= '0;
            mask_q     <= isa_dma_pkg::MASK_RESET;
            soft_req_q <= '0;
            tc_flag_q  <= '0;
            for (int i = 0; i < 4; i++)
                mode_q[i] <= '0;
        end
        else
        begin
            // A terminal count in the same cycle as a status read is kept
            tc_flag_q <= (reg_rd && off == isa_dma_pkg::OFF_STATUS_CMD ? 4'h0 : tc_flag_q) | tc_out;
            if (reg_wr)
            begin
                unique case (off)
                    isa_dma_pkg::OFF_STATUS_CMD:  command_q <= mcu_wdata_in;
                    isa_dma_pkg::OFF_REQUEST:     soft_req_q[mcu_wdata_in[1:0]] <= mcu_wdata_in[2];
                    isa_dma_pkg::OFF_SINGLE_MASK:
                        mask_q[mcu_wdata_in[1:0]] <= mcu_wdata_in[isa_dma_pkg::MASK_SET_BIT];
                    isa_dma_pkg::OFF_MODE:        mode_q[mcu_wdata_in[1:0]] <= mcu_wdata_in; // Bit positions kept
                    isa_dma_pkg::OFF_CLEAR_MASK:  mask_q <= 4'h0;
                    isa_dma_pkg::OFF_ALL_MASK:    mask_q <= mcu_wdata_in[3:0];
                    default:                      ;
                endcase
            end
            // End of a non-autoinit run masks the channel; last so it beats a mask write
            for (int i = 0; i < 4; i++)
                if (tc_out[i])
                begin
                    soft_req_q[i] <= 1'b0;
                    if (!mode_q[i][isa_dma_pkg::MODE_AUTO_BIT])
                        mask_q[i] <= 1'b1;
                end
        end
    end

    // Register read mux: channel bytes by pointer, status, else zero
    always_comb
    begin
        read_value = isa_dma_pkg::READ_ZERO;
        if (off <= isa_dma_pkg::OFF_CHAN_LAST)
        begin
            if (!off[0])
                read_value = byte_pointer_q ? cur_addr_q[off_ch][15:8] : cur_addr_q[off_ch][7:0];
            else
                read_value = byte_pointer_q ? cur_count_q[off_ch][15:8] : cur_count_q[off_ch][7:0];
        end
        else if (off == isa_dma_pkg::OFF_STATUS_CMD)
            read_value = {dreq_in, tc_flag_q};
    end

    // MCU read answer one cycle later; other window cycles go to the ISA bus
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            mcu_rdata_out    <= '0;
            mcu_rvalid_out   <= 1'b0;
            isa_io_out       <= '0;
            isa_io_valid_out <= 1'b0;
        end
        else
        begin
            mcu_rvalid_out   <= mcu_rd_in;
            mcu_rdata_out    <= reg_rd ? read_value
                              : (mcu_rd_in && mcu_addr_in == isa_dma_pkg::IO_BASE_REG_ADDR)
                              ? io_window_base_q : isa_dma_pkg::READ_ZERO;
            isa_io_valid_out <= io_window_hit && !dma_hit && (mcu_rd_in || mcu_wr_in);
            isa_io_out       <= '{write: mcu_wr_in, addr: io_addr, data: mcu_wdata_in};
        end
    end

    // Checks on the design's own outputs and internal registers
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    chk_ext_upper_low: assert property (mem_req_valid_out && !mem_req_out.internal_external_select
        |-> mem_req_out.isa_addr[19:15] == 5'h00 && mem_req_out.isa_addr[14:0] == cur_addr_q[active_q][14:0])
        else $error("external DMA address high bits not low");
    chk_int_ptr_low: assert property (mem_req_valid_out && mem_req_out.internal_external_select
        |-> !mem_req_out.pointer[10] && mem_req_out.pointer[9:0] == cur_addr_q[active_q][9:0])
        else $error("internal pointer bit ten not forced low");
    chk_packet_window: assert property (start |=> mem_req_valid_out
        && mem_req_out.packet_number_field == $past(cur_addr_q[pick][14:10])
        && mem_req_out.internal_external_select == $past(cur_addr_q[pick][15]))
        else $error("packet number not taken from window index");
    chk_io_upper_only: assert property (mem_req_valid_out && mem_req_out.io_cycle
        |-> active_q >= 2'h2 && !mem_req_out.internal_external_select)
        else $error("I/O capability on a low channel");
    chk_ptr_toggle: assert property (chan_access && !(reg_wr && off >= isa_dma_pkg::OFF_CLEAR_PTR)
        |=> byte_pointer_q != $past(byte_pointer_q))
        else $error("byte pointer did not toggle");
    chk_ptr_clear: assert property (reg_wr && off == isa_dma_pkg::OFF_CLEAR_PTR
        |=> !byte_pointer_q ##1 ($past(chan_access) || !byte_pointer_q))
        else $error("byte pointer not cleared");
    chk_held_refused: assert property (dma_hit && mcu_wr_in && hold_ack_in && !mcu_rd_in
        |=> $stable(byte_pointer_q) && $stable(mask_q))
        else $error("register write taken while bus held");
    chk_read_answer: assert property (reg_rd && off == isa_dma_pkg::OFF_STATUS_CMD
        |=> mcu_rvalid_out && mcu_rdata_out[3:0] == $past(tc_flag_q))
        else $error("status read answer wrong");
    chk_window_end: assert property (done && window_end |=> tc_out != 4'h0)
        else $error("window end did not end the transfer");
    chk_io_base: assert property (isa_io_valid_out |-> isa_io_out.addr[15:8] == io_window_base_q)
        else $error("ISA I/O high address not from window base");

    cov_internal_xfer: cover property (mem_req_valid_out && mem_req_out.internal_external_select ##[1:8] done);
    cov_terminal: cover property (tc_out != 4'h0);
    cov_fifo_full: cover property (!dma_data_ready_out ##1 dma_data_ready_out);
    cov_header_skip: cover property (mem_req_valid_out && mem_req_out.internal_external_select
        && mem_req_out.pointer == 11'(isa_dma_pkg::HEADER_BYTES));
endmodule

`default_nettype wire

// ===== test/isa_dma_far_memory.sv
// Far-side memory model that answers DMA memory cycles
`timescale 1ns/1ps
`default_nettype none
module isa_dma_far_memory (
    input  wire logic sys_clk_in,
    input  wire logic reset_in,
    input  wire logic slow_in,
    input  wire logic mem_req_valid_in,
    output logic      mem_ready_out
);
    logic [1:0] wait_q;
    // Answer at once or after three idle cycles; ready never lingers past the taken cycle
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in || !mem_req_valid_in || mem_ready_out)
        begin
            wait_q        <= slow_in ? 2'h3 : 2'h0;
            mem_ready_out <= 1'b0;
        end
        else if (wait_q != 2'h0)
            wait_q <= wait_q - 2'h1;
        else
            mem_ready_out <= 1'b1;
    end
endmodule
`default_nettype wire

// ===== test/isa_dma_address_mapping_bench.sv
// Self-checking bench for the ISA DMA address mapping block
`timescale 1ns/1ps
`default_nettype none
module isa_dma_address_mapping_bench;
    logic                         clk  = 1'b0;
    logic                         rst  = 1'b1;
    logic                         wr   = 1'b0;
    logic                         rd   = 1'b0;
    logic                         hold = 1'b0;
    logic                         dv   = 1'b0;
    logic                         slow = 1'b0;
    logic [15:0]                  addr = 16'h0000;
    logic [7:0]                   wd   = 8'h00;
    logic [7:0]                   dd   = 8'h00;
    logic [3:0]                   dreq = 4'h0;
    logic [7:0]                   rdata;
    logic                         rvalid, iov, dready, mval, mrdy, hreq;
    logic [3:0]                   dack, tc;
    isa_dma_pkg::io_cycle_type    io;
    isa_dma_pkg::mem_request_type mreq;
    logic [31:0]                  exp_q[$];
    logic [31:0]                  r;
    int                           mismatches = 0;
    int                           n_tests = 0;
    // Packet and pointer matter only for internal cycles, the ISA address only for external
    wire logic [31:0] mem_seen = {6'h0, mreq.internal_external_select, mreq.io_cycle, dack,
        mreq.internal_external_select ? {4'h0, mreq.packet_number_field, mreq.pointer} : mreq.isa_addr};

    always #2 clk = ~clk;

    isa_dma_address_mapping isa_dma_address_mapping_inst (.sys_clk_in(clk), .reset_in(rst),
        .mcu_addr_in(addr), .mcu_wr_in(wr), .mcu_rd_in(rd), .mcu_wdata_in(wd), .mcu_rdata_out(rdata),
        .mcu_rvalid_out(rvalid), .isa_io_out(io), .isa_io_valid_out(iov), .dreq_in(dreq), .dack_out(dack),
        .hold_request_out(hreq), .hold_ack_in(hold), .dma_data_valid_in(dv), .dma_data_ready_out(dready),
        .dma_data_in(dd), .mem_req_out(mreq), .mem_req_valid_out(mval), .mem_ready_in(mrdy), .tc_out(tc));
    isa_dma_far_memory isa_dma_far_memory_inst (.sys_clk_in(clk), .reset_in(rst), .slow_in(slow),
        .mem_req_valid_in(mval), .mem_ready_out(mrdy));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle strobe; the idle edge after it keeps back-to-back calls apart
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic tally_and_finish;
        if (mismatches == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Each result takes the oldest note off the queue
    always @(posedge clk)
    begin
        if (rvalid === 1'b1)
            check("rdata", {24'h0, rdata}, exp_q.pop_front());
        if (iov === 1'b1)
            check("isa_io", {7'h0, io}, exp_q.pop_front());
        if (mval === 1'b1 && mrdy === 1'b1)
            check("mem_req", mem_seen, exp_q.pop_front());
    end

    initial
    begin
        r = $urandom(83306);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        acc(1'b1, 16'h400C, 8'h00);
        for (int i = 0; i < 4; i++)
            acc(1'b1, 16'h4000 + 16'(i / 2), r[8 * i +: 8]);
        hold <= 1'b1;
        acc(1'b1, 16'h4000, ~r[7:0]);
        hold <= 1'b0;
        acc(1'b1, 16'h400C, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            exp_q.push_back({24'h0, r[8 * i +: 8]});
            acc(1'b0, 16'h4000 + 16'(i / 2), 8'h00);
        end
        exp_q.push_back(32'h0);
        acc(1'b0, 16'h1234, 8'h00);
        acc(1'b1, 16'h7F71, 8'h3A);
        exp_q.push_back({7'h0, 1'b1, 16'h3A05, r[7:0]});
        acc(1'b1, 16'h4005, r[7:0]);
        acc(1'b1, 16'h7F71, 8'h00);
        acc(1'b1, 16'h4008, 8'h00);
        dv <= 1'b1;
        dd <= r[7:0];
        // Zero count keeps each channel to one cycle; odd channels internal, channel 1 moves FIFO data
        for (int ch = 0; ch < 4; ch++)
        begin
            r = $urandom;
            r[15] = ch[0];
            slow <= ch[1];
            acc(1'b1, 16'h400C, 8'h00);
            acc(1'b1, 16'h4000 + 16'(2 * ch), r[7:0]);
            acc(1'b1, 16'h4000 + 16'(2 * ch), r[15:8]);
            acc(1'b1, 16'h4001 + 16'(2 * ch), 8'h00);
            acc(1'b1, 16'h4001 + 16'(2 * ch), 8'h00);
            acc(1'b1, 16'h400B, (ch == 1 ? 8'h04 : 8'h08) | 8'(ch));
            acc(1'b1, 16'h400A, 8'(ch));
            exp_q.push_back({6'h0, r[15], !r[15] && ch >= 2, 4'(1 << ch),
                r[15] ? {4'h0, r[14:10], 1'b0, r[9:0]} : {5'h0, r[14:0]}});
            dreq[ch] <= 1'b1;
            hold <= 1'b1;
            for (int k = 0; k < 40 && !(mval === 1'b1 && mrdy === 1'b1); k++)
                @(posedge clk);
            check("hold_req", {31'h0, hreq}, 32'h1);
            if (ch == 1)
                check("mem_data", {24'h0, mreq.data}, {24'h0, dd});
            dreq <= 4'h0;
            hold <= 1'b0;
            @(posedge clk);
            check("tc", {28'h0, tc}, 32'(1 << ch));
            repeat (3) @(posedge clk);
        end
        // Every channel ended on a zero count; the first status read clears the flags
        exp_q.push_back(32'h0F);
        acc(1'b0, 16'h4008, 8'h00);
        exp_q.push_back(32'h0);
        acc(1'b0, 16'h4008, 8'h00);
        repeat (20) @(posedge clk);
        check("fifo_ready", {31'h0, dready}, 32'h0);
        dv <= 1'b0;
        check("notes_left", exp_q.size(), 32'h0);
        tally_and_finish();
    end

    // Watchdog well past the expected run length
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
